// *** design/sxc_pkg.sv ***
package sxc_pkg;
   localparam int NCH = 6;
   localparam int CW  = 16;
   localparam int AW  = 8;

   // register byte offsets
   localparam logic [7:0] A_SF0  = 8'h00;
   localparam logic [7:0] A_SF1  = 8'h04;
   localparam logic [7:0] A_PCLK = 8'h08;
   localparam logic [7:0] A_IST  = 8'h0c;
   localparam logic [7:0] A_IMSK = 8'h10;
   localparam logic [7:0] A_MODE = 8'h20;
   localparam logic [7:0] A_CNT  = 8'h40;

   // field positions
   localparam int RUN_LO  = 5;
   localparam int RUN_HI  = 7;
   localparam int MD_LO   = 0;
   localparam int MD_HI   = 1;
   localparam int EDG_LO  = 2;
   localparam int EDG_HI  = 3;
   localparam int SRC_LO  = 6;
   localparam int SRC_HI  = 7;
   localparam int PCLK_B  = 0;

   // reset values
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [5:0] RUN_RST  = 6'h00;

   // prescaler tap masks and tick indices
   localparam logic [4:0] M_F2  = 5'h01;
   localparam logic [4:0] M_F8  = 5'h07;
   localparam logic [4:0] M_F32 = 5'h1f;
   localparam int T_F1   = 0;
   localparam int T_F2   = 1;
   localparam int T_F8   = 2;
   localparam int T_F32  = 3;
   localparam int T_SUBCLOCK_DIV32 = 4;

   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_TIMER, MODE_EVENT, MODE_MEAS, MODE_RSVD
   } sxc_mode_e;

   typedef enum logic [1:0] {
      SRC_F1, SRC_F8, SRC_F32, SRC_SUBCLOCK_DIV32
   } sxc_src_e;
endpackage : sxc_pkg

// *** design/sxc_ch_if.sv ***
`timescale 1ns/1ps
interface sxc_ch_if;
   logic        tick;
   logic        run;
   logic        active;
   logic        wr;
   logic [15:0] wdata;
   logic [15:0] count;
   logic        uf;
   modport top (output tick, run, active, wr, wdata, input count, uf);
   modport ch  (input tick, run, active, wr, wdata, output count, uf);
endinterface : sxc_ch_if

// *** design/sxc_prescaler.sv ***
`timescale 1ns/1ps
module sxc_prescaler (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       ce,
   input  wire logic       fc_edge,
   output logic [4:0]      tick
);
   logic [4:0] div_reg;
   logic [4:0] sub_reg;

   function automatic logic due(input logic [4:0] v, input logic [4:0] m);
      return (v & m) == m;
   endfunction : due

   // free divider of the system clock
   always_ff @(posedge aclk) begin
      if (!aresetn) div_reg <= 5'h00;
      else if (ce) div_reg <= div_reg + 5'h01;
   end

   // subclock edges divided by 32
   always_ff @(posedge aclk) begin
      if (!aresetn) sub_reg <= 5'h00;
      else if (ce && fc_edge) sub_reg <= sub_reg + 5'h01;
   end

   // one-cycle ticks; f2, f8 and f32 aligned to the same divider phase, the subclock tick has its own counter
   assign tick[sxc_pkg::T_F1]   = 1'b1;
   assign tick[sxc_pkg::T_F2]   = due(div_reg, sxc_pkg::M_F2);
   assign tick[sxc_pkg::T_F8]   = due(div_reg, sxc_pkg::M_F8);
   assign tick[sxc_pkg::T_F32]  = due(div_reg, sxc_pkg::M_F32);
   assign tick[sxc_pkg::T_SUBCLOCK_DIV32] = fc_edge && due(sub_reg, sxc_pkg::M_F32);

   property p_nest;
      @(posedge aclk) disable iff (!aresetn)
      tick[sxc_pkg::T_F32] |-> tick[sxc_pkg::T_F8] && tick[sxc_pkg::T_F2]
         ##1 (!$past(ce) || !tick[sxc_pkg::T_F8]);
   endproperty
   a_nest: assert property (p_nest) else $error("prescaler taps not nested");
endmodule : sxc_prescaler

// *** design/sxc_channel.sv ***
`timescale 1ns/1ps
module sxc_channel (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic ce,
   sxc_ch_if.ch      bus
);
   logic [15:0] cnt_reg;
   logic [15:0] rld_reg;
   logic        first_reg;
   logic        uf_reg;
   logic        go;
   logic        zero;
   logic        wr_ok;

   assign go    = bus.run && bus.active && bus.tick;
   assign zero  = cnt_reg == 16'h0000;
   assign wr_ok = bus.wr && bus.active; // measurement mode ignores writes

   // first tick since start; stopping re-arms the dual write
   always_ff @(posedge aclk) begin
      if (!aresetn) first_reg <= 1'b0;
      else if (ce) begin
         if (!bus.run) first_reg <= 1'b0;
         else if (go) first_reg <= 1'b1;
      end
   end

   // reload register takes every accepted write
   always_ff @(posedge aclk) begin
      if (!aresetn) rld_reg <= 16'h0000;
      else if (ce && wr_ok) rld_reg <= bus.wdata;
   end

   // counter: tick beats a concurrent early write
   always_ff @(posedge aclk) begin
      if (!aresetn) cnt_reg <= 16'h0000;
      else if (ce) begin
         if (go) cnt_reg <= zero ? rld_reg : cnt_reg - 16'h0001;
         else if (wr_ok && !first_reg) cnt_reg <= bus.wdata;
      end
   end

   // registered underflow: breaks the chaining ring combinationally
   always_ff @(posedge aclk) begin
      if (!aresetn) uf_reg <= 1'b0;
      else if (ce) uf_reg <= go && zero;
   end

   assign bus.count = cnt_reg;
   assign bus.uf    = uf_reg;

   sequence s_wrap;
      ce && go && zero;
   endsequence
   property p_reload;
      @(posedge aclk) disable iff (!aresetn)
      s_wrap |=> uf_reg && cnt_reg == $past(rld_reg);
   endproperty
   a_reload: assert property (p_reload) else $error("no reload");

   property p_dec;
      @(posedge aclk) disable iff (!aresetn)
      ce && go && !zero |=> cnt_reg == $past(cnt_reg) - 16'h0001 && !uf_reg;
   endproperty
   a_dec: assert property (p_dec) else $error("bad decrement");

   property p_hold;
      @(posedge aclk) disable iff (!aresetn)
      ce && !bus.run && !bus.wr |=> $stable(cnt_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("stopped counter moved");

   property p_wr_both;
      @(posedge aclk) disable iff (!aresetn)
      ce && wr_ok && !first_reg && !go
      |=> cnt_reg == $past(bus.wdata) && rld_reg == $past(bus.wdata);
   endproperty
   a_wr_both: assert property (p_wr_both) else $error("dual write lost");

   property p_wr_rld;
      @(posedge aclk) disable iff (!aresetn)
      ce && wr_ok && first_reg && !go
      |=> cnt_reg == $past(cnt_reg) && rld_reg == $past(bus.wdata);
   endproperty
   a_wr_rld: assert property (p_wr_rld) else $error("counter overwritten");
endmodule : sxc_channel

// *** design/sxc_top.sv ***
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sxc_top (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   ce,
   input  wire logic [sxc_pkg::AW-1:0] awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   input  wire logic [sxc_pkg::AW-1:0] araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   input  wire logic [5:0]             external_count_input,
   input  wire logic                   subclock_in,
   output logic                        irq
);
   localparam int NCH = sxc_pkg::NCH;

   // register file
   logic [5:0]  run_reg;
   logic        pclk_reg;
   logic [5:0]  ist_reg;
   logic [5:0]  imsk_reg;
   logic [7:0]  mode_reg [NCH];

   // write channel capture
   logic [7:0]  waddr_reg;
   logic        aw_full_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        w_full_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        do_wr;
   logic        wr_ok;

   // read channel
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic [31:0] rd_data;
   logic        rd_ok;

   // pins and ticks
   logic [6:0]  sync1_reg;
   logic [6:0]  sync2_reg;
   logic [6:0]  prev_reg;
   logic [6:0]  rise;
   logic [6:0]  fall;
   logic [4:0]  tick;
   logic [15:0] cnt_w [NCH];
   logic [5:0]  uf_w;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a[7:2] == off[7:2];
   endfunction : hit

   function automatic logic [7:0] slot(input logic [7:0] base, input int i);
      return base + 8'(4 * i);
   endfunction : slot

   // two-flop synchronisers, third stage only for edge detection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= 7'h00;
         sync2_reg <= 7'h00;
         prev_reg  <= 7'h00;
      end else if (ce) begin
         sync1_reg <= {subclock_in, external_count_input};
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   assign rise = sync2_reg & ~prev_reg;
   assign fall = ~sync2_reg & prev_reg;

   sxc_prescaler u_pre (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .fc_edge (rise[6]),
      .tick    (tick)
   );

   sxc_ch_if chb [NCH] ();

   // per-channel source selection and register wiring
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      localparam int PRV    = (i % 3 == 0) ? i + 2 : i - 1;
      localparam bit PIN_OK = (i != 2);
      sxc_pkg::sxc_mode_e md;
      sxc_pkg::sxc_src_e  src;
      logic               tmr_tick;
      logic               pin_edge;
      logic               evt_tick;

      assign md  = sxc_pkg::sxc_mode_e'(mode_reg[i][sxc_pkg::MD_HI:
                                                   sxc_pkg::MD_LO]);
      assign src = sxc_pkg::sxc_src_e'(mode_reg[i][sxc_pkg::SRC_HI:
                                                   sxc_pkg::SRC_LO]);

      // internal source; clock select picks f1 or f2 on code zero
      always_comb begin
         case (src)
            sxc_pkg::SRC_F1:   tmr_tick = pclk_reg ? tick[sxc_pkg::T_F1]
                                                   : tick[sxc_pkg::T_F2];
            sxc_pkg::SRC_F8:   tmr_tick = tick[sxc_pkg::T_F8];
            sxc_pkg::SRC_F32:  tmr_tick = tick[sxc_pkg::T_F32];
            sxc_pkg::SRC_SUBCLOCK_DIV32: tmr_tick = tick[sxc_pkg::T_SUBCLOCK_DIV32];
            default:           tmr_tick = 1'b0;
         endcase
      end

      // pin polarity: falling, rising or both edges
      always_comb begin
         case (mode_reg[i][sxc_pkg::EDG_HI:sxc_pkg::EDG_LO])
            2'h0:    pin_edge = fall[i];
            2'h1:    pin_edge = rise[i];
            default: pin_edge = rise[i] | fall[i];
         endcase
      end

      // channel 2 has no usable pin, so its pin path reads zero
      assign evt_tick = mode_reg[i][sxc_pkg::SRC_HI] ? uf_w[PRV]
                      : (PIN_OK && pin_edge);

      assign chb[i].tick   = (md == sxc_pkg::MODE_TIMER) ? tmr_tick : evt_tick;
      assign chb[i].active = (md == sxc_pkg::MODE_TIMER) ||
                             (md == sxc_pkg::MODE_EVENT);
      assign chb[i].run    = run_reg[i];
      assign chb[i].wr     = do_wr && hit(waddr_reg, slot(sxc_pkg::A_CNT, i))
                             && (&wstrb_reg[1:0]);
      assign chb[i].wdata  = wdata_reg[15:0];
      assign cnt_w[i]      = chb[i].count;
      assign uf_w[i]       = chb[i].uf;

      sxc_channel u_ch (
         .aclk    (aclk),
         .aresetn (aresetn),
         .ce      (ce),
         .bus     (chb[i])
      );
   end

   // write address and data are taken independently, in either order
   assign awready = !aw_full_reg;
   assign wready  = !w_full_reg;
   assign do_wr   = aw_full_reg && w_full_reg && !bvalid_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         waddr_reg   <= 8'h00;
      end else if (ce) begin
         if (awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            waddr_reg   <= awaddr;
         end else if (do_wr) aw_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_reg <= 1'b0;
         wdata_reg  <= 32'h0000_0000;
         wstrb_reg  <= 4'h0;
      end else if (ce) begin
         if (wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            wdata_reg  <= wdata;
            wstrb_reg  <= wstrb;
         end else if (do_wr) w_full_reg <= 1'b0;
      end
   end

   // mapped-address check for the write response
   always_comb begin
      wr_ok = hit(waddr_reg, sxc_pkg::A_SF0) || hit(waddr_reg, sxc_pkg::A_SF1)
           || hit(waddr_reg, sxc_pkg::A_PCLK) || hit(waddr_reg, sxc_pkg::A_IST)
           || hit(waddr_reg, sxc_pkg::A_IMSK);
      for (int i = 0; i < NCH; i++) begin
         if (hit(waddr_reg, slot(sxc_pkg::A_MODE, i)) ||
             hit(waddr_reg, slot(sxc_pkg::A_CNT, i))) wr_ok = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= sxc_pkg::RESP_OK;
      end else if (ce) begin
         if (do_wr) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_ok ? sxc_pkg::RESP_OK : sxc_pkg::RESP_ERR;
         end else if (bready) bvalid_reg <= 1'b0;
      end
   end

   // run bits, clock select and mask need byte lane 0
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_reg  <= sxc_pkg::RUN_RST;
         pclk_reg <= 1'b0;
         imsk_reg <= 6'h00;
      end else if (ce && do_wr && wstrb_reg[0]) begin
         if (hit(waddr_reg, sxc_pkg::A_SF0))
            run_reg[2:0] <= wdata_reg[sxc_pkg::RUN_HI:sxc_pkg::RUN_LO];
         if (hit(waddr_reg, sxc_pkg::A_SF1))
            run_reg[5:3] <= wdata_reg[sxc_pkg::RUN_HI:sxc_pkg::RUN_LO];
         if (hit(waddr_reg, sxc_pkg::A_PCLK))
            pclk_reg <= wdata_reg[sxc_pkg::PCLK_B];
         if (hit(waddr_reg, sxc_pkg::A_IMSK))
            imsk_reg <= wdata_reg[5:0];
      end
   end

   // mode registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NCH; i++) mode_reg[i] <= sxc_pkg::MODE_RST;
      end else if (ce && do_wr && wstrb_reg[0]) begin
         for (int i = 0; i < NCH; i++) begin
            if (hit(waddr_reg, slot(sxc_pkg::A_MODE, i)))
               mode_reg[i] <= wdata_reg[7:0];
         end
      end
   end

   // sticky underflow flags; a new underflow beats a write-one clear
   always_ff @(posedge aclk) begin
      if (!aresetn) ist_reg <= 6'h00;
      else if (ce) begin
         if (do_wr && wstrb_reg[0] && hit(waddr_reg, sxc_pkg::A_IST))
            ist_reg <= (ist_reg & ~wdata_reg[5:0]) | uf_w;
         else
            ist_reg <= ist_reg | uf_w;
      end
   end

   assign irq = |(ist_reg & imsk_reg);

   // read decode; unmapped reads give zero and an error response
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_ok   = 1'b1;
      if (hit(araddr, sxc_pkg::A_SF0))
         rd_data[sxc_pkg::RUN_HI:sxc_pkg::RUN_LO] = run_reg[2:0];
      else if (hit(araddr, sxc_pkg::A_SF1))
         rd_data[sxc_pkg::RUN_HI:sxc_pkg::RUN_LO] = run_reg[5:3];
      else if (hit(araddr, sxc_pkg::A_PCLK))
         rd_data[sxc_pkg::PCLK_B] = pclk_reg;
      else if (hit(araddr, sxc_pkg::A_IST))
         rd_data[5:0] = ist_reg;
      else if (hit(araddr, sxc_pkg::A_IMSK))
         rd_data[5:0] = imsk_reg;
      else begin
         rd_ok = 1'b0;
         for (int i = 0; i < NCH; i++) begin
            if (hit(araddr, slot(sxc_pkg::A_MODE, i))) begin
               rd_data[7:0] = mode_reg[i];
               rd_ok        = 1'b1;
            end
            if (hit(araddr, slot(sxc_pkg::A_CNT, i))) begin
               rd_data[15:0] = cnt_w[i];
               rd_ok         = 1'b1;
            end
         end
      end
   end

   assign arready = !rvalid_reg;

   // read data registered one cycle after the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= sxc_pkg::RESP_OK;
      end else if (ce) begin
         if (arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_data;
            rresp_reg  <= rd_ok ? sxc_pkg::RESP_OK : sxc_pkg::RESP_ERR;
         end else if (rready) rvalid_reg <= 1'b0;
      end
   end

   assign bvalid = bvalid_reg;
   assign bresp  = bresp_reg;
   assign rvalid = rvalid_reg;
   assign rdata  = rdata_reg;
   assign rresp  = rresp_reg;

   property p_run_bits;
      @(posedge aclk) disable iff (!aresetn)
      ce && do_wr && wstrb_reg[0] && hit(waddr_reg, sxc_pkg::A_SF1)
      |=> run_reg[5:3] == $past(wdata_reg[7:5]);
   endproperty
   a_run_bits: assert property (p_run_bits) else $error("run bits wrong");

   property p_rd_cnt;
      @(posedge aclk) disable iff (!aresetn)
      ce && arvalid && arready && hit(araddr, sxc_pkg::A_CNT)
      |=> rvalid && rdata == {16'h0000, $past(cnt_w[0])};
   endproperty
   a_rd_cnt: assert property (p_rd_cnt) else $error("count read wrong");

   sequence s_uf_seen;
      ce && (uf_w & imsk_reg) != 6'h00 && !do_wr;
   endsequence
   property p_irq;
      @(posedge aclk) disable iff (!aresetn)
      s_uf_seen |=> irq && (ist_reg & $past(uf_w)) == $past(uf_w);
   endproperty
   a_irq: assert property (p_irq) else $error("underflow irq missing");
endmodule : sxc_top

// *** verif/sxc_pulse_src.sv ***
`timescale 1ns/1ps
// far-side pulse source: square pulses on the count pins, free sub-clock
module sxc_pulse_src (
   input  wire logic       aclk,
   input  wire logic [5:0] req,
   output logic [5:0]      pins,
   output logic            subclock
);
   logic [2:0] ph_reg [6];
   logic [2:0] sc_reg;

   // each pin high 4 cycles, low 4, only while requested; idle low
   for (genvar g = 0; g < 6; g++) begin : g_pin
      always_ff @(posedge aclk) begin
         ph_reg[g] <= req[g] ? ph_reg[g] + 3'h1 : 3'h0;
      end
      assign pins[g] = req[g] & ph_reg[g][2];
   end

   // sub-clock runs free, slower than the system clock
   // plain always: the start value comes from the initial block
   initial sc_reg = 3'h0;
   always @(posedge aclk) begin
      sc_reg <= sc_reg + 3'h1;
   end
   assign subclock = sc_reg[2];
endmodule : sxc_pulse_src

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, irq, subclock;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rv;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rr;
   logic [5:0]  req, pins;
   int          fails, n_checks;

   typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} sxc_row_s;
   sxc_row_s rows [10];

   sxc_top u_sxc_top (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .external_count_input(pins), .subclock_in(subclock),
      .irq(irq));
   sxc_pulse_src u_sxc_pulse_src (.aclk(aclk), .req(req), .pins(pins),
      .subclock(subclock));

   // clock
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop

   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // a hang counts as a mismatch and closes the run
   task hang;
      fails++;
      $display("[FAIL] bus wait expected answer seen none");
      report_and_stop();
   endtask : hang

   // write: address and data offered together, each dropped when taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            rr = bresp;
            break;
         end
      end
      if (i == 100) hang();
      // bready stays high between writes: no second drive in one step
   endtask : wr

   // read: result lands in rv and rr
   task rd(input logic [7:0] a);
      int i;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            rv = rdata;
            rr = rresp;
            break;
         end
      end
      if (i == 100) hang();
      // rready stays high between reads, as bready does for writes
   endtask : rd

   // k whole pulses on one pin, then let the synchroniser settle
   task pulse(input int ch, input int k);
      req[ch] <= 1'b1;
      repeat (8 * k) @(posedge aclk);
      req[ch] <= 1'b0;
      repeat (8) @(posedge aclk);
   endtask : pulse

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, req} = '0;
      wstrb = 4'hf;
      fails = 0;
      n_checks = 0;
      rows = '{'{8'h00, 0, 0}, '{8'h04, 0, 0}, '{8'h08, 0, 0},
               '{8'h0c, 0, 0}, '{8'h10, 0, 0}, '{8'h20, 0, 0},
               '{8'h34, 0, 0}, '{8'h40, 0, 0}, '{8'h54, 0, 0},
               '{8'h3c, 0, 2'h2}};
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // reset values and the unmapped hole
      foreach (rows[i]) begin
         rd(rows[i].a);
         chk("reset data", rv, rows[i].d);
         chk("reset resp", {30'h0, rr}, {30'h0, rows[i].r});
      end
      chk("irq idle", {31'h0, irq}, 32'h0);
      wr(8'h3c, 32'h0);
      chk("write hole resp", {30'h0, rr}, 32'h2);
      $display("test reset done");

      // ch1 pin events rising, ch2 chained on ch1 underflows
      wr(8'h24, 32'h05);
      chk("write resp", {30'h0, rr}, 32'h0);
      wr(8'h28, 32'h85);
      wr(8'h44, 32'h2);
      wr(8'h48, 32'h1);
      rd(8'h44);
      chk("load stopped", rv, 32'h2);
      wr(8'h00, 32'hc0);
      rd(8'h00);
      chk("run bits ch1 ch2", rv, 32'hc0);
      pulse(1, 1);
      rd(8'h44);
      chk("live count", rv, 32'h1);
      wr(8'h44, 32'h5);
      rd(8'h44);
      chk("reload only", rv, 32'h1);
      pulse(1, 2);
      rd(8'h44);
      chk("reload taken", rv, 32'h5);
      rd(8'h0c);
      chk("uf after n+1", rv, 32'h02);
      rd(8'h48);
      chk("chain step", rv, 32'h0);
      pulse(1, 5);
      rd(8'h0c);
      chk("no early uf", rv, 32'h02);
      pulse(1, 1);
      rd(8'h0c);
      chk("chain uf", rv, 32'h06);
      rd(8'h48);
      chk("chain reload", rv, 32'h1);
      $display("test event chain done");

      // mask, raise and clear the interrupt
      chk("irq masked", {31'h0, irq}, 32'h0);
      wr(8'h10, 32'h04);
      chk("irq unmasked", {31'h0, irq}, 32'h1);
      wr(8'h0c, 32'h04);
      rd(8'h0c);
      chk("w1c", rv, 32'h02);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      $display("test irq done");

      // stopped channel ignores pin edges
      wr(8'h00, 32'h00);
      pulse(1, 2);
      rd(8'h44);
      chk("held stopped", rv, 32'h5);
      // ch0 counts falling edges, n = 0 underflows every tick
      wr(8'h20, 32'h01);
      wr(8'h40, 32'h0);
      wr(8'h00, 32'h20);
      wr(8'h10, 32'h05);
      pulse(0, 1);
      rd(8'h0c);
      chk("falling edge uf", rv, 32'h03);
      chk("irq ch0", {31'h0, irq}, 32'h1);
      $display("test stop and polarity done");

      // ch3 timer on f1; run bit in the second start register
      wr(8'h08, 32'h1);
      wr(8'h2c, 32'h00);
      wr(8'h4c, 32'hffff);
      wr(8'h04, 32'h20);
      repeat (20) @(posedge aclk);
      rd(8'h4c);
      chk("timer counts", {31'h0, rv[15:0] < 16'hffff}, 32'h1);
      wr(8'h04, 32'h00);
      rd(8'h4c);
      wdata <= rv;
      repeat (20) @(posedge aclk);
      rd(8'h4c);
      chk("timer held", rv, wdata);
      // measurement mode on ch4 drops count writes (never ch2)
      wr(8'h30, 32'h02);
      wr(8'h50, 32'h7);
      rd(8'h50);
      chk("meas no load", rv, 32'h0);
      // ch4 timer on f32: any 64 system cycles hold exactly two ticks
      wr(8'h30, 32'h80);
      wr(8'h50, 32'h10);
      wr(8'h04, 32'h40);
      repeat (63) @(posedge aclk);
      rd(8'h50);
      chk("f32 ticks", rv, 32'he);
      $display("test timer and modes done");

      // reset in mid-run clears counters, run bits and the interrupt
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("irq after reset", {31'h0, irq}, 32'h0);
      rd(8'h50);
      chk("count after reset", rv, 32'h0);
      rd(8'h04);
      chk("run after reset", rv, 32'h0);
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule : tb
